/* File: src/diag_regs_pkg.sv */
// constants, register map and carrier types for the diagnostic status bank
// assumes a 100 MHz system clock and a 32-bit APB master in front
package diag_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFS_FUSE     = 8'h00;
   localparam logic [7:0] OFS_DIP      = 8'h04;
   localparam logic [7:0] OFS_DIAG     = 8'h08;
   localparam logic [7:0] OFS_ERR_YM   = 8'h0C;
   localparam logic [7:0] OFS_ERR_DH   = 8'h10;
   localparam logic [7:0] OFS_ERR_MS   = 8'h14;
   localparam logic [7:0] OFS_CLASS    = 8'h18;
   localparam logic [7:0] OFS_DETAIL   = 8'h1C;
   localparam logic [7:0] OFS_RUN      = 8'h20;
   localparam logic [7:0] OFS_CYCLE    = 8'h24;
   localparam logic [7:0] OFS_MAXCYC   = 8'h28;
   localparam logic [7:0] OFS_CALYM    = 8'h2C;
   localparam logic [7:0] OFS_CTRL     = 8'h30;
   localparam logic [3:0] REG_LAST_IDX = 4'hC;

   // control register bits, write-one pulses
   localparam int CTRL_CLR_STOP_BIT = 0;
   localparam int CTRL_CLR_MAX_BIT  = 1;

   // run state register codes
   localparam logic [3:0] CODE_RUN     = 4'h0;
   localparam logic [3:0] CODE_STOP    = 4'h2;
   localparam logic [3:0] CAUSE_SWITCH = 4'h0;
   localparam logic [3:0] CAUSE_ERROR  = 4'h4;

   // supply dip thresholds in percent of rating
   localparam logic [7:0] DIP_AC_PCT = 8'h55;
   localparam logic [7:0] DIP_DC_PCT = 8'h41;

   // reset values and limits
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] CYCLE_SAT = 16'hFFFF;

   // millisecond tick derived from the clock rate
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_PERIOD_NS  = 1000000;
   localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [15:0] year_month;
      logic [15:0] day_hour;
      logic [15:0] min_sec;
   } bcd_time_t;

   typedef struct packed {
      logic [15:0] number;
      logic [15:0] cls;
      logic [15:0] detail;
      logic        detail_is_cpu;
      logic [1:0]  cpu_idx;
      logic        stop;
   } fault_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_STOP = 2'b10
   } run_state_t;

endpackage : diag_regs_pkg

/* File: src/diag_status_regs.sv */
// diagnostic and status register bank with an APB slave port
// assumes fault, fuse, supply and main-pass inputs are on CLK_SYS_I;
// the run/stop switch is a raw pin and is synchronised here
module diag_status_regs #(
   parameter int unsigned MS_CYCLES = diag_regs_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic                      CLK_SYS_I,
   input  wire logic                      RST_I,
   // apb slave
   input  wire logic                      PSEL_I,
   input  wire logic                      PENABLE_I,
   input  wire logic                      PWRITE_I,
   input  wire logic [7:0]                PADDR_I,
   input  wire logic [31:0]               PWDATA_I,
   output logic      [31:0]               PRDATA_O,
   output logic                           PREADY_O,
   output logic                           PSLVERR_O,
   // cpu operation and supply monitor
   input  wire logic                      RUN_SWITCH_I,
   input  wire logic                      CPU_OPERATING_I,
   input  wire logic [7:0]                SUPPLY_PCT_I,
   input  wire logic                      SUPPLY_DC_I,
   // i/o modules
   input  wire logic [15:0]               FUSE_BLOWN_I,
   // self-diagnosis
   input  wire logic                      FAULT_VALID_I,
   input  wire diag_regs_pkg::fault_t     FAULT_I,
   // time of day and main processing
   input  wire diag_regs_pkg::bcd_time_t  TIME_NOW_I,
   input  wire logic                      CAL_LOAD_I,
   input  wire logic                      MAIN_PASS_I,
   // status out
   output logic                           CPU_STOPPED_O
);

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic        setup_rd;
   logic        acc_wr;
   logic        addr_ok;
   logic [3:0]  reg_idx;
   logic        wr_calym;
   logic        wr_ctrl;
   logic        clr_stop;
   logic        clr_max;
   logic [15:0] rd_word [0:12];
   logic [15:0] rd_sel;
   logic [31:0] prdata_q;

   assign reg_idx  = PADDR_I[5:2];
   assign addr_ok  = (PADDR_I[1:0] == 2'b00) && (PADDR_I[7:6] == 2'b00)
                     && (reg_idx <= diag_regs_pkg::REG_LAST_IDX);
   assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
   assign acc_wr   = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
   // writable registers, selected ones only
   assign wr_calym = acc_wr && (PADDR_I == diag_regs_pkg::OFS_CALYM);
   assign wr_ctrl  = acc_wr && (PADDR_I == diag_regs_pkg::OFS_CTRL);
   assign clr_stop = wr_ctrl && PWDATA_I[diag_regs_pkg::CTRL_CLR_STOP_BIT];
   assign clr_max  = wr_ctrl && PWDATA_I[diag_regs_pkg::CTRL_CLR_MAX_BIT];
   assign rd_sel   = addr_ok ? rd_word[reg_idx] : 16'h0000;

   // zero wait states: data is registered in the setup cycle
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
   assign PRDATA_O  = prdata_q;

   // read data latched in setup so it is stable through access
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_q <= {16'h0000, rd_sel};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run/stop switch synchroniser
   // resets to the run level so leaving reset never fakes a switch stop
   logic run_sw_meta_q;
   logic run_sw_q;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         run_sw_meta_q <= 1'b1;
         run_sw_q      <= 1'b1;
      end else begin
         run_sw_meta_q <= RUN_SWITCH_I;
         run_sw_q      <= run_sw_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lowest blown-fuse module, searched from the top down
   logic [3:0] fuse_low;
   logic       fuse_any;
   logic [15:0] fuse_idx_q;

   assign fuse_any = |FUSE_BLOWN_I;

   always_comb begin
      fuse_low = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (FUSE_BLOWN_I[i]) begin
            fuse_low = 4'(i);
         end
      end
   end

   // refreshed each main pass; with no blown fuse the last value holds
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         fuse_idx_q <= diag_regs_pkg::REG_RESET;
      end else if (MAIN_PASS_I && fuse_any) begin
         fuse_idx_q <= {12'h000, fuse_low};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power dip counter, edge of the below-threshold condition
   logic [7:0]  dip_limit;
   logic        below;
   logic        below_q;
   logic        dip_evt;
   logic [15:0] dip_cnt_q;

   assign dip_limit = SUPPLY_DC_I ? diag_regs_pkg::DIP_DC_PCT
                                  : diag_regs_pkg::DIP_AC_PCT;
   assign below     = (SUPPLY_PCT_I <= dip_limit);
   // only counted while the cpu is operating; one dip counts once
   assign dip_evt   = below && !below_q && CPU_OPERATING_I;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         below_q   <= 1'b0;
         dip_cnt_q <= diag_regs_pkg::REG_RESET;
      end else begin
         below_q <= below;
         if (dip_evt) begin
            dip_cnt_q <= dip_cnt_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fault capture: number, time stamp, class and detail
   logic [15:0] detail_val;
   logic [15:0] diag_num_q;
   logic [15:0] err_ym_q;
   logic [15:0] err_dh_q;
   logic [15:0] err_ms_q;
   logic [15:0] class_q;
   logic [15:0] detail_q;

   // cpu numbers are one-based in the register
   assign detail_val = FAULT_I.detail_is_cpu ?
                       ({14'h0000, FAULT_I.cpu_idx} + 16'h0001) : FAULT_I.detail;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         diag_num_q <= diag_regs_pkg::REG_RESET;
         err_ym_q   <= diag_regs_pkg::REG_RESET;
         err_dh_q   <= diag_regs_pkg::REG_RESET;
         err_ms_q   <= diag_regs_pkg::REG_RESET;
         class_q    <= diag_regs_pkg::REG_RESET;
         detail_q   <= diag_regs_pkg::REG_RESET;
      end else if (FAULT_VALID_I) begin
         diag_num_q <= FAULT_I.number;
         err_ym_q   <= TIME_NOW_I.year_month;
         err_dh_q   <= TIME_NOW_I.day_hour;
         err_ms_q   <= TIME_NOW_I.min_sec;
         class_q    <= FAULT_I.cls;
         detail_q   <= detail_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cpu run state and stop cause
   diag_regs_pkg::run_state_t state_q;
   logic        err_stop_q;
   logic        stop_req;
   logic [3:0]  cause_q;
   logic [15:0] run_reg_q;
   logic [3:0]  state_code;

   assign stop_req   = !run_sw_q || err_stop_q;
   assign state_code = (state_q == diag_regs_pkg::ST_STOP) ?
                       diag_regs_pkg::CODE_STOP : diag_regs_pkg::CODE_RUN;
   assign CPU_STOPPED_O = (state_q == diag_regs_pkg::ST_STOP);

   // error stop: a new stop fault beats a clear in the same cycle
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         err_stop_q <= 1'b0;
      end else if (FAULT_VALID_I && FAULT_I.stop) begin
         err_stop_q <= 1'b1;
      end else if (clr_stop) begin
         err_stop_q <= 1'b0;
      end
   end

   // cause latched on entry to stop and held; later causes do not replace it
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         state_q <= diag_regs_pkg::ST_RUN;
         cause_q <= diag_regs_pkg::CAUSE_SWITCH;
      end else begin
         unique case (state_q)
            diag_regs_pkg::ST_RUN: begin
               if (stop_req) begin
                  state_q <= diag_regs_pkg::ST_STOP;
                  cause_q <= !run_sw_q ? diag_regs_pkg::CAUSE_SWITCH
                                       : diag_regs_pkg::CAUSE_ERROR;
               end
            end
            diag_regs_pkg::ST_STOP: begin
               if (!stop_req) begin
                  state_q <= diag_regs_pkg::ST_RUN;
                  cause_q <= diag_regs_pkg::CAUSE_SWITCH;
               end
            end
         endcase
      end
   end

   // visible state register follows main processing
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         run_reg_q <= diag_regs_pkg::REG_RESET;
      end else if (MAIN_PASS_I) begin
         run_reg_q <= {8'h00, cause_q, state_code};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main cycle timing in milliseconds
   logic [16:0] presc_q;
   logic        ms_tick;
   logic [15:0] ms_cnt_q;
   logic [15:0] cycle_q;
   logic [15:0] max_q;

   assign ms_tick = (presc_q == 17'(MS_CYCLES - 1));

   // prescaler restarts at each pass so each cycle is timed from its start
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         presc_q  <= 17'h00000;
         ms_cnt_q <= 16'h0000;
      end else if (MAIN_PASS_I) begin
         presc_q  <= 17'h00000;
         ms_cnt_q <= 16'h0000;
      end else begin
         presc_q <= ms_tick ? 17'h00000 : presc_q + 17'h00001;
         if (ms_tick && ms_cnt_q != diag_regs_pkg::CYCLE_SAT) begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
         end
      end
   end

   // new maximum wins over a clear request in the same cycle
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         cycle_q <= diag_regs_pkg::REG_RESET;
         max_q   <= diag_regs_pkg::REG_RESET;
      end else begin
         if (MAIN_PASS_I) begin
            cycle_q <= ms_cnt_q;
         end
         if (MAIN_PASS_I && ms_cnt_q > max_q) begin
            max_q <= ms_cnt_q;
         end else if (clr_max) begin
            max_q <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calendar year-month, user write beats a system load
   logic [15:0] calym_q;

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         calym_q <= diag_regs_pkg::REG_RESET;
      end else if (wr_calym) begin
         calym_q <= PWDATA_I[15:0];
      end else if (CAL_LOAD_I) begin
         calym_q <= TIME_NOW_I.year_month;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read words in map order; control reads zero
   assign rd_word[0]  = fuse_idx_q;
   assign rd_word[1]  = dip_cnt_q;
   assign rd_word[2]  = diag_num_q;
   assign rd_word[3]  = err_ym_q;
   assign rd_word[4]  = err_dh_q;
   assign rd_word[5]  = err_ms_q;
   assign rd_word[6]  = class_q;
   assign rd_word[7]  = detail_q;
   assign rd_word[8]  = run_reg_q;
   assign rd_word[9]  = cycle_q;
   assign rd_word[10] = max_q;
   assign rd_word[11] = calym_q;
   assign rd_word[12] = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   dip_count_a: assert property (dip_evt |=> dip_cnt_q == $past(dip_cnt_q) + 16'h0001)
      else $error("dip counter did not step");
   dip_idle_a: assert property (!below |=> $stable(dip_cnt_q))
      else $error("dip counter moved above threshold");
   fault_number_a: assert property (FAULT_VALID_I |=> diag_num_q == $past(FAULT_I.number)
                                    && class_q == $past(FAULT_I.cls))
      else $error("fault number or class not captured");
   error_time_a: assert property (FAULT_VALID_I |=> err_ym_q == $past(TIME_NOW_I.year_month)
                                  && err_ms_q == $past(TIME_NOW_I.min_sec))
      else $error("error time not captured with fault");
   cpu_number_a: assert property (FAULT_VALID_I && FAULT_I.detail_is_cpu |=>
                                  detail_q >= 16'h0001 && detail_q <= 16'h0004)
      else $error("cpu number out of 1 to 4");
   state_code_a: assert property (MAIN_PASS_I && CPU_STOPPED_O |=>
                                  run_reg_q[3:0] == diag_regs_pkg::CODE_STOP)
      else $error("stop state code wrong");
   switch_cause_a: assert property (state_q == diag_regs_pkg::ST_RUN && !run_sw_q |=>
                                    CPU_STOPPED_O ##0 cause_q == diag_regs_pkg::CAUSE_SWITCH)
      else $error("switch stop cause wrong");
   cause_hold_a: assert property (CPU_STOPPED_O && $past(CPU_STOPPED_O) |-> $stable(cause_q))
      else $error("stop cause changed while stopped");
   cycle_sat_a: assert property (ms_cnt_q == diag_regs_pkg::CYCLE_SAT && !MAIN_PASS_I |=>
                                 ms_cnt_q == diag_regs_pkg::CYCLE_SAT)
      else $error("cycle count wrapped");
   max_mono_a: assert property (MAIN_PASS_I && !clr_max |=>
                                max_q >= $past(max_q) && max_q >= cycle_q)
      else $error("maximum cycle below latest");
   fuse_low_a: assert property (MAIN_PASS_I && fuse_any |=>
                                (($past(FUSE_BLOWN_I) >> fuse_idx_q[3:0]) & 16'h0001) != 16'h0000
                                && ($past(FUSE_BLOWN_I) & ((16'h0001 << fuse_idx_q[3:0])
                                - 16'h0001)) == 16'h0000)
      else $error("fuse index not lowest blown");
   cal_write_a: assert property (wr_calym |=> calym_q == $past(PWDATA_I[15:0]))
      else $error("calendar write lost");
   // readback, refresh and load paths
   diag_read_a: assert property (setup_rd && PADDR_I == diag_regs_pkg::OFS_DIAG |=>
                                 PRDATA_O == {16'h0000, $past(diag_num_q)})
      else $error("diag number read back wrong");
   ro_write_a: assert property (acc_wr && !FAULT_VALID_I &&
                                PADDR_I == diag_regs_pkg::OFS_DIAG |=> $stable(diag_num_q))
      else $error("read-only register took a write");
   detail_plain_a: assert property (FAULT_VALID_I && !FAULT_I.detail_is_cpu |=>
                                    detail_q == $past(FAULT_I.detail))
      else $error("plain error detail not captured");
   dip_off_a: assert property (!CPU_OPERATING_I |=> $stable(dip_cnt_q))
      else $error("dip counted while cpu idle");
   run_code_a: assert property (MAIN_PASS_I && !CPU_STOPPED_O |=>
                                run_reg_q[3:0] == diag_regs_pkg::CODE_RUN)
      else $error("run state code wrong");
   cycle_refresh_a: assert property (MAIN_PASS_I |=> cycle_q == $past(ms_cnt_q))
      else $error("cycle time not refreshed on pass");
   cal_load_a: assert property (CAL_LOAD_I && !wr_calym |=>
                                calym_q == $past(TIME_NOW_I.year_month))
      else $error("calendar system load lost");
   error_stop_a: assert property (FAULT_VALID_I && FAULT_I.stop |=> err_stop_q)
      else $error("error stop not latched");

   dip_seen_c: cover property (dip_evt ##[1:20] dip_evt);
   cpu_detail_c: cover property (FAULT_VALID_I && FAULT_I.detail_is_cpu);
   error_stop_c: cover property (CPU_STOPPED_O && cause_q == diag_regs_pkg::CAUSE_ERROR);
   max_rise_c: cover property (MAIN_PASS_I && ms_cnt_q > max_q && max_q != 16'h0000);

endmodule : diag_status_regs

/* File: tb/tb_diag_status_regs.sv */
// self-checking bench for the diagnostic status register bank
// assumes the design package is compiled first; drives every port itself
module tb_diag_status_regs;
   timeunit 1ns;
   timeprecision 1ps;

   // short millisecond so cycle-time counts stay quick
   localparam int unsigned MS_SIM = 20;

   logic                     clk_sys = 1'b0;
   logic                     rst     = 1'b1;
   logic                     psel    = 1'b0;
   logic                     penable = 1'b0;
   logic                     pwrite  = 1'b0;
   logic [7:0]               paddr   = 8'h00;
   logic [31:0]              pwdata  = 32'h0;
   logic [31:0]              prdata;
   logic                     pready;
   logic                     pslverr;
   logic                     run_sw  = 1'b1;
   logic                     cpu_op  = 1'b0;
   logic [7:0]               pct     = 8'h64;
   logic                     dc      = 1'b0;
   logic [15:0]              fuse    = 16'h0;
   logic                     f_valid = 1'b0;
   diag_regs_pkg::fault_t    fault   = '0;
   diag_regs_pkg::bcd_time_t now     = '0;
   logic                     cal_ld  = 1'b0;
   logic                     pass    = 1'b0;
   logic                     stopped;
   int                       n_mismatch = 0;
   int                       compares   = 0;
   logic [31:0]              rdata;
   logic                     rerr;

   diag_status_regs #(.MS_CYCLES(MS_SIM)) diag_status_regs_i (
      .CLK_SYS_I(clk_sys), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .RUN_SWITCH_I(run_sw),
      .CPU_OPERATING_I(cpu_op), .SUPPLY_PCT_I(pct), .SUPPLY_DC_I(dc),
      .FUSE_BLOWN_I(fuse), .FAULT_VALID_I(f_valid), .FAULT_I(fault),
      .TIME_NOW_I(now), .CAL_LOAD_I(cal_ld), .MAIN_PASS_I(pass),
      .CPU_STOPPED_O(stopped));

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high, then one
   // idle edge so two calls never drive psel twice in one time step
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) begin
            rdata = prdata;
            rerr  = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
            return;
         end
      end
      n_mismatch++;
      finish_test();
   endtask : apb

   task automatic reg_chk(input string name, input logic [7:0] addr, input logic [15:0] exp);
      apb(1'b0, addr, 32'h0);
      chk(name, {16'h0000, exp}, rdata);
      chk("slverr", 32'h0, {31'h0, rerr});
   endtask : reg_chk

   // end-of-pass pulse, then let the registers settle
   task automatic main_pass();
      pass <= 1'b1;
      @(posedge clk_sys);
      pass <= 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys);
   endtask : main_pass

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_map();
      reg_chk("diag", diag_regs_pkg::OFS_DIAG, 16'h0000);
      reg_chk("maxcyc", diag_regs_pkg::OFS_MAXCYC, 16'h0000);
      apb(1'b0, 8'h34, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      apb(1'b0, 8'h02, 32'h0);
      chk("misaligned err", 32'h1, {31'h0, rerr});
      chk("misaligned data", 32'h0, rdata);
      apb(1'b1, diag_regs_pkg::OFS_DIAG, 32'h0000_BEEF);
      reg_chk("ro write", diag_regs_pkg::OFS_DIAG, 16'h0000);
      $display("test reset_map done");
   endtask : t_reset_map

   task automatic t_fuse();
      fuse <= 16'h0A08;
      main_pass();
      reg_chk("fuse low", diag_regs_pkg::OFS_FUSE, 16'h0003);
      fuse <= 16'h8000;
      main_pass();
      reg_chk("fuse top", diag_regs_pkg::OFS_FUSE, 16'h000F);
      fuse <= 16'h0000;
      main_pass();
      reg_chk("fuse none", diag_regs_pkg::OFS_FUSE, 16'h000F);
      $display("test fuse done");
   endtask : t_fuse

   task automatic dip(input logic [7:0] p, input logic d, input logic op);
      dc     <= d;
      cpu_op <= op;
      @(posedge clk_sys);
      pct <= p;
      repeat (2) @(posedge clk_sys);
      pct <= 8'h64;
      repeat (2) @(posedge clk_sys);
   endtask : dip

   task automatic t_dip();
      dip(8'd86, 1'b0, 1'b1);
      dip(8'd85, 1'b0, 1'b1);
      dip(8'd66, 1'b1, 1'b1);
      dip(8'd65, 1'b1, 1'b1);
      dip(8'd10, 1'b0, 1'b0);
      reg_chk("dip count", diag_regs_pkg::OFS_DIP, 16'h0002);
      $display("test dip done");
   endtask : t_dip

   task automatic raise_fault(input logic [1:0] idx, input logic stp);
      fault.number        <= 16'h1B58;
      fault.cls           <= 16'h0001;
      fault.detail        <= 16'h0000;
      fault.detail_is_cpu <= 1'b1;
      fault.cpu_idx       <= idx;
      fault.stop          <= stp;
      f_valid             <= 1'b1;
      @(posedge clk_sys);
      f_valid <= 1'b0;
      @(posedge clk_sys);
   endtask : raise_fault

   task automatic t_fault();
      now <= '{year_month: 16'h9510, day_hour: 16'h3110, min_sec: 16'h3548};
      for (int i = 0; i < 4; i++) begin
         raise_fault(i[1:0], 1'b0);
         reg_chk("cpu detail", diag_regs_pkg::OFS_DETAIL, 16'(i + 1));
      end
      // plain detail word, not a cpu number
      fault.detail_is_cpu <= 1'b0;
      fault.detail        <= 16'h0123;
      f_valid             <= 1'b1;
      @(posedge clk_sys);
      f_valid <= 1'b0;
      @(posedge clk_sys);
      reg_chk("plain detail", diag_regs_pkg::OFS_DETAIL, 16'h0123);
      reg_chk("diag number", diag_regs_pkg::OFS_DIAG, 16'h1B58);
      reg_chk("err ym", diag_regs_pkg::OFS_ERR_YM, 16'h9510);
      reg_chk("err dh", diag_regs_pkg::OFS_ERR_DH, 16'h3110);
      reg_chk("err ms", diag_regs_pkg::OFS_ERR_MS, 16'h3548);
      reg_chk("class", diag_regs_pkg::OFS_CLASS, 16'h0001);
      $display("test fault done");
   endtask : t_fault

   task automatic t_run_state();
      raise_fault(2'd0, 1'b1);
      main_pass();
      reg_chk("error stop", diag_regs_pkg::OFS_RUN, 16'h0042);
      chk("stopped", 32'h1, {31'h0, stopped});
      apb(1'b1, diag_regs_pkg::OFS_CTRL, 32'h0000_0001);
      main_pass();
      reg_chk("run again", diag_regs_pkg::OFS_RUN, 16'h0000);
      run_sw <= 1'b0;
      repeat (4) @(posedge clk_sys);
      main_pass();
      reg_chk("switch stop", diag_regs_pkg::OFS_RUN, 16'h0002);
      raise_fault(2'd1, 1'b1);
      main_pass();
      reg_chk("earliest cause", diag_regs_pkg::OFS_RUN, 16'h0002);
      apb(1'b1, diag_regs_pkg::OFS_CTRL, 32'h0000_0001);
      run_sw <= 1'b1;
      repeat (4) @(posedge clk_sys);
      main_pass();
      reg_chk("resumed", diag_regs_pkg::OFS_RUN, 16'h0000);
      chk("running", 32'h0, {31'h0, stopped});
      $display("test run_state done");
   endtask : t_run_state

   task automatic t_cycle();
      // earlier tests leave long cycles in the maximum, so start from zero
      apb(1'b1, diag_regs_pkg::OFS_CTRL, 32'h0000_0002);
      main_pass();
      repeat (65) @(posedge clk_sys);
      main_pass();
      reg_chk("cycle long", diag_regs_pkg::OFS_CYCLE, 16'h0003);
      reg_chk("max long", diag_regs_pkg::OFS_MAXCYC, 16'h0003);
      main_pass();
      reg_chk("cycle short", diag_regs_pkg::OFS_CYCLE, 16'h0000);
      reg_chk("max held", diag_regs_pkg::OFS_MAXCYC, 16'h0003);
      apb(1'b1, diag_regs_pkg::OFS_CTRL, 32'h0000_0002);
      main_pass();
      reg_chk("max cleared", diag_regs_pkg::OFS_MAXCYC, 16'h0000);
      $display("test cycle done");
   endtask : t_cycle

   task automatic t_calendar();
      now.year_month <= 16'h9307;
      cal_ld         <= 1'b1;
      @(posedge clk_sys);
      cal_ld <= 1'b0;
      @(posedge clk_sys);
      reg_chk("cal system", diag_regs_pkg::OFS_CALYM, 16'h9307);
      apb(1'b1, diag_regs_pkg::OFS_CALYM, 32'h0000_2412);
      reg_chk("cal user", diag_regs_pkg::OFS_CALYM, 16'h2412);
      $display("test calendar done");
   endtask : t_calendar

   ////////////////////////////////////////////////////////////////////////////
   // main sequence; reset held for two clocks
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset_map();
      t_fuse();
      t_dip();
      t_fault();
      t_run_state();
      t_cycle();
      t_calendar();
      finish_test();
   end

   // watchdog so a stuck run still reaches the verdict
   initial begin
      repeat (50000) @(posedge clk_sys);
      n_mismatch++;
      finish_test();
   end

endmodule : tb_diag_status_regs
